//--- bench/dceclk_bench.sv
// self-checking bench for the dual comparator event control block
`timescale 1ns/1ps
module dceclk_bench;
   import dceclk_pkg::*;
   //----------------------------------------------------------------
   // stimulus and observed signals
   //----------------------------------------------------------------
   logic i_ref_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [1:0] i_cmp_raw = 2'h0;
   logic [PORT_W-1:0] i_port_pins = '0;
   logic [31:0] o_rdata;
   logic [1:0] o_noninv_sel_ref;
   logic [3:0] o_inv_sel;
   logic [1:0] o_cmp_enable;
   logic [1:0] o_comparator_out_pin;
   logic [1:0] o_output_pin_enable;
   logic o_irq;
   int bad_count = 0;
   int comparisons = 0;
   int seed = 32'h23A47215;
   logic [31:0] v;
   logic [31:0] w;
   // model of both control registers, kept by the bench
   logic [31:0] d [2];

   dceclk_top u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_raw(i_cmp_raw), .i_port_pins(i_port_pins),
      .o_noninv_sel_ref(o_noninv_sel_ref), .o_inv_sel(o_inv_sel), .o_cmp_enable(o_cmp_enable),
      .o_comparator_out_pin(o_comparator_out_pin), .o_output_pin_enable(o_output_pin_enable), .o_irq(o_irq));

   initial
   begin
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   //----------------------------------------------------------------
   // bus tasks and comparison
   //----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one idle edge after each strobe, so no strobe is assigned twice in a step
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat);
      i_addr <= a;
      i_wdata <= dat;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 check(name, o_rdata, exp);
      @(posedge i_ref_clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic test_done;
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   //----------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      @(posedge i_ref_clk);
      rdchk("ctrl one reset", OFS_CTRL1, CTRL_RST);
      rdchk("ctrl two reset", OFS_CTRL2, CTRL_RST);
      rdchk("priority reset", OFS_PRIO, 32'h0);
      #1 check("irq reset", 32'(o_irq), 32'h0);
      @(posedge i_ref_clk);
      for (int k = 0; k < 6; k++)
      begin
         v = (k == 0) ? 32'hFFFFFFFF : $random(seed);
         wr(OFS_PRIO, v);
         rdchk("priority", OFS_PRIO, v & PRIO_WMASK);
      end
      wr(4'hF, 32'hFFFFFFFF);
      rdchk("unmapped", 4'hF, 32'h0);
      wr(OFS_STAT, 32'hFFFFFFFF);
      rdchk("status write", OFS_STAT, 32'h0);
      // random configurations of both comparators
      for (int k = 0; k < 8; k++)
      begin
         // unmasked words go out, so read-only and reserved bits are really tried
         v = (k == 0) ? 32'hFFFFFFFF : $random(seed);
         w = $random(seed);
         d[0] = v & CTRL_WMASK;
         d[1] = w & CTRL_WMASK;
         i_cmp_raw <= 2'($random(seed));
         wr(OFS_CTRL1, v);
         wr(OFS_CTRL2, w);
         idle(6);
         check("noninv sel", 32'(o_noninv_sel_ref), 32'({d[1][B_REF], d[0][B_REF]}));
         check("inv sel", 32'(o_inv_sel), 32'({d[1][1:0], d[0][1:0]}));
         check("enables", 32'({o_output_pin_enable, o_cmp_enable}),
            32'({d[1][B_OE], d[0][B_OE], d[1][B_ON], d[0][B_ON]}));
         for (int c = 0; c < 2; c++)
         begin
            w = 32'(i_cmp_raw[c] ^ d[c][B_INV]);
            check("pin", 32'(o_comparator_out_pin[c]), w & 32'(d[c][B_OE]));
            rdchk("ctrl", c[ADDR_W-1:0], d[c] | (w << B_RES));
         end
         rdchk("status", OFS_STAT, 32'({i_cmp_raw[1] ^ d[1][B_INV], i_cmp_raw[0] ^ d[0][B_INV]}));
      end
      // every edge code with both polarities on both comparators
      for (int n = 0; n < 16; n++)
      begin
         int c;
         int code;
         int pol;
         int en;
         int set;
         c = n % 2;
         code = (n / 2) % 4;
         pol = n / 8;
         en = $random(seed) & 3;
         i_cmp_raw <= 2'h0;
         d[c] = (1 << B_ON) | (1 << B_OE) | (code << B_EVL) | (pol << B_INV) | 32'(CH_FIXED);
         // pin direction is software's job, the bench always enables the output
         wr(c[ADDR_W-1:0], d[c]);
         idle(8);
         // a configuration change may leave a false event, so clear it first
         wr(OFS_ICLR, 32'h3);
         wr(OFS_IEN, 32'(en));
         rdchk("irq enable", OFS_IEN, 32'(en));
         i_cmp_raw[c] <= 1'b1;
         // pin follows at once, long before the synchroniser has caught up
         #1 check("pin raw", 32'(o_comparator_out_pin[c]), 32'(1 ^ pol));
         idle(8);
         set = pol ? code / 2 : code % 2;
         rdchk("pending rise", OFS_ISTAT, 32'(set << c));
         #1 check("irq", 32'(o_irq), 32'(((set << c) & en) != 0));
         wr(OFS_ICLR, 32'h3);
         rdchk("pending clear", OFS_ISTAT, 32'h0);
         #1 check("irq clear", 32'(o_irq), 32'h0);
         i_cmp_raw[c] <= 1'b0;
         idle(8);
         set = pol ? code % 2 : code / 2;
         rdchk("pending fall", OFS_ISTAT, 32'(set << c));
      end
      // port reads with random analog configuration
      for (int k = 0; k < 4; k++)
      begin
         v = $random(seed);
         w = $random(seed) & 32'hFF;
         i_port_pins <= v[PORT_W-1:0];
         wr(OFS_ANCFG, w);
         idle(6);
         rdchk("port", OFS_PORT, 32'(v[PORT_W-1:0] & ~w[PORT_W-1:0]));
      end
      test_done;
   end

   // a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge i_ref_clk);
      bad_count++;
      test_done;
   end
endmodule

//--- hdl/dceclk_pkg.sv
// constants for the dual comparator event control block
//----------------------------------------------------------------
// Notes on behaviour
// - comparator two priority field, bits 20:18, zero disables, one..seven priority. The code only stores it; o_irq does not use it.
// - comparator two subpriority field, two bits, values zero to three.
// - comparator one priority field at bits 12:10, zero disables. The code only stores it; o_irq does not use it.
// - comparator one subpriority field at bits 9:8, values zero to three.
// - each comparator picks noninverting input: pin or programmable reference.
// - each comparator picks inverting input: three pins or fixed reference.
// - per comparator event detection on chosen level change or any change.
// - result low when noninverting below inverting, high when above.
// - result readable in status register and control bit 8, read-only.
// - output pin carries raw unsynchronised result; register bit stays valid.
// - result bit read returns a sample latched at read time.
// - polarity bit 13 of each control register inverts the output.
// - port input read returns zero for analog-configured pins.
// - edge field: 11 both, 10 falling, 01 rising, 00 disabled.
// - polarity also inverts the signal feeding the event detector.
//----------------------------------------------------------------
package dceclk_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_CTRL1 = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CTRL2 = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_STAT = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_PRIO = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_ISTAT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_ICLR = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_IEN = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_PORT = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_ANCFG = 4'h8;
   // control register fields
   localparam int B_ON = 15;
   localparam int B_OE = 14;
   localparam int B_INV = 13;
   localparam int B_RES = 8;
   localparam int B_EVH = 7;
   localparam int B_EVL = 6;
   localparam int B_REF = 4;
   localparam int B_CHH = 1;
   localparam int B_CHL = 0;
   localparam logic [31:0] CTRL_WMASK = 32'h0000E0D3;
   localparam logic [31:0] CTRL_RST = 32'h000000C3;
   // priority register fields
   localparam int P2_H = 20;
   localparam int P2_L = 18;
   localparam int S2_H = 17;
   localparam int S2_L = 16;
   localparam int P1_H = 12;
   localparam int P1_L = 10;
   localparam int S1_H = 9;
   localparam int S1_L = 8;
   localparam logic [31:0] PRIO_WMASK = 32'h001F1F00;
   // event edge encodings
   localparam logic [1:0] EV_OFF = 2'h0;
   localparam logic [1:0] EV_RISE = 2'h1;
   localparam logic [1:0] EV_FALL = 2'h2;
   localparam logic [1:0] EV_BOTH = 2'h3;
   // inverting input selections
   localparam logic [1:0] CH_OWN_NEG = 2'h0;
   localparam logic [1:0] CH_OWN_POS = 2'h1;
   localparam logic [1:0] CH_OTH_POS = 2'h2;
   localparam logic [1:0] CH_FIXED = 2'h3;
   localparam int PORT_W = 8;
endpackage

//--- hdl/dceclk_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module dceclk_sync #(
   parameter int W = 2
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } dceclk_sync_s;
   dceclk_sync_s st_reg, st_next;

   //----------------------------------------------------------------
   // synchroniser chain
   //----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = i_async;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // change taken only once second and third stages agree
      for (int k = 0; k < W; k++)
      begin
         if (st_reg.s2[k] == st_reg.s3[k])
         begin
            st_next.val[k] = st_reg.s3[k];
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign o_sync = st_reg.val;
endmodule

//--- hdl/dceclk_top.sv
// dual comparator event control: registers, routing, events
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dceclk_top
   import dceclk_pkg::*;
#(
   parameter int PW = dceclk_pkg::PORT_W
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [dceclk_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [1:0] i_cmp_raw,
   input wire logic [PW-1:0] i_port_pins,
   output logic [1:0] o_noninv_sel_ref,
   output logic [3:0] o_inv_sel,
   output logic [1:0] o_cmp_enable,
   output logic [1:0] o_comparator_out_pin,
   output logic [1:0] o_output_pin_enable,
   output logic o_irq
);
   import dceclk_pkg::*;

   typedef struct packed {
      logic [31:0] ctrl1;
      logic [31:0] ctrl2;
      logic [31:0] prio;
      logic [1:0] prev;
      logic [1:0] pend;
      logic [1:0] ien;
      logic [PW-1:0] ancfg;
      logic [31:0] rdata;
   } dceclk_s;
   dceclk_s st_reg, st_next;

   logic [1:0] cmp_sync;
   logic [1:0] inv;
   logic [1:0] polar;
   logic [1:0] evt;
   logic [PW-1:0] port_sync;

   function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
      logic r;
      logic f;
      r = !prv && cur;
      f = prv && !cur;
      case (sel)
         EV_RISE: edge_hit = r;
         EV_FALL: edge_hit = f;
         EV_BOTH: edge_hit = r || f;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   //----------------------------------------------------------------
   // input synchronisers
   //----------------------------------------------------------------
   // synchronise comparator outputs
   dceclk_sync #(.W(2)) u_cmp_sync (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_async(i_cmp_raw),
      .o_sync(cmp_sync)
   );

   dceclk_sync #(.W(PW)) u_port_sync (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_async(i_port_pins),
      .o_sync(port_sync)
   );

   //----------------------------------------------------------------
   // polarity and events
   //----------------------------------------------------------------
   always_comb
   begin
      inv[0] = st_reg.ctrl1[B_INV];
      inv[1] = st_reg.ctrl2[B_INV];
      polar = cmp_sync ^ inv;
      evt[0] = st_reg.ctrl1[B_ON] && edge_hit(st_reg.ctrl1[B_EVH:B_EVL], st_reg.prev[0], polar[0]);
      evt[1] = st_reg.ctrl2[B_ON] && edge_hit(st_reg.ctrl2[B_EVH:B_EVL], st_reg.prev[1], polar[1]);
   end

   //----------------------------------------------------------------
   // register file
   //----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.prev = polar;
      st_next.rdata = 32'h00000000;
      // set wins over clear so no event is lost
      if (i_wr && i_addr == OFS_ICLR)
      begin
         st_next.pend = st_reg.pend & ~i_wdata[1:0];
      end
      st_next.pend = st_next.pend | evt;
      if (i_wr)
      begin
         case (i_addr)
            OFS_CTRL1: st_next.ctrl1 = i_wdata & CTRL_WMASK;
            OFS_CTRL2: st_next.ctrl2 = i_wdata & CTRL_WMASK;
            OFS_PRIO: st_next.prio = i_wdata & PRIO_WMASK;
            OFS_IEN: st_next.ien = i_wdata[1:0];
            OFS_ANCFG: st_next.ancfg = i_wdata[PW-1:0];
            default: st_next.ien = st_reg.ien;
         endcase
      end
      if (i_rd)
      begin
         // sample taken at read, the read data register is the latch
         case (i_addr)
            OFS_CTRL1: st_next.rdata = st_reg.ctrl1 | {23'h000000, polar[0], 8'h00};
            OFS_CTRL2: st_next.rdata = st_reg.ctrl2 | {23'h000000, polar[1], 8'h00};
            OFS_STAT: st_next.rdata = {30'h00000000, polar};
            OFS_PRIO: st_next.rdata = st_reg.prio;
            OFS_ISTAT: st_next.rdata = {30'h00000000, st_reg.pend};
            OFS_IEN: st_next.rdata = {30'h00000000, st_reg.ien};
            OFS_PORT: st_next.rdata = 32'(port_sync & ~st_reg.ancfg);
            OFS_ANCFG: st_next.rdata = 32'(st_reg.ancfg);
            default: st_next.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         st_reg <= '0;
         st_reg.ctrl1 <= CTRL_RST;
         st_reg.ctrl2 <= CTRL_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   assign o_rdata = st_reg.rdata;
   assign o_irq = |(st_reg.pend & st_reg.ien);
   assign o_cmp_enable = {st_reg.ctrl2[B_ON], st_reg.ctrl1[B_ON]};
   assign o_noninv_sel_ref = {st_reg.ctrl2[B_REF], st_reg.ctrl1[B_REF]};
   assign o_inv_sel = {st_reg.ctrl2[B_CHH:B_CHL], st_reg.ctrl1[B_CHH:B_CHL]};
   assign o_output_pin_enable = {st_reg.ctrl2[B_OE], st_reg.ctrl1[B_OE]};
   // raw path: no synchroniser delay on the pin, glitches pass too
   assign o_comparator_out_pin = (i_cmp_raw ^ inv) & o_output_pin_enable;

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   AST_IRQ_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (evt[0] && st_reg.ien[0]) |=> o_irq)
      else $error("enabled event did not raise interrupt");
   AST_OFF_NO_EVT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl1[B_EVH:B_EVL] == EV_OFF) |-> !evt[0])
      else $error("event with detection disabled");
   AST_RISE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl1[B_ON] && st_reg.ctrl1[B_EVH:B_EVL] == EV_RISE && !st_reg.prev[0] && polar[0]) |=> st_reg.pend[0])
      else $error("rising edge missed");
   AST_RD_STAT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_rd && i_addr == OFS_STAT) |=> o_rdata == {30'h00000000, $past(polar)})
      else $error("status read mismatch");
   AST_RD_BIT8: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_rd && i_addr == OFS_CTRL2) |=> o_rdata[B_RES] == $past(polar[1]))
      else $error("result bit not sampled at read");
   AST_PRIO: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_PRIO) |=> st_reg.prio[P2_H:P2_L] == $past(i_wdata[P2_H:P2_L])
      && st_reg.prio[P1_H:P1_L] == $past(i_wdata[P1_H:P1_L]))
      else $error("priority not stored");
   AST_SUB: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_PRIO) |=> st_reg.prio[S1_H:S1_L] == $past(i_wdata[S1_H:S1_L])
      && st_reg.prio[S2_H:S2_L] == $past(i_wdata[S2_H:S2_L]))
      else $error("subpriority not stored");
   AST_PORT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_rd && i_addr == OFS_PORT) |=> (o_rdata[PW-1:0] & $past(st_reg.ancfg)) == '0)
      else $error("analog pin read nonzero");
   AST_PIN: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !o_output_pin_enable[0] |-> !o_comparator_out_pin[0])
      else $error("pin driven while disabled");

   //----------------------------------------------------------------
   // checks: event detection on both comparators
   //----------------------------------------------------------------
   AST_IRQ_SET2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (evt[1] && st_reg.ien[1]) |=> o_irq)
      else $error("enabled event two did not raise interrupt");

   AST_OFF_NO_EVT2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl2[B_EVH:B_EVL] == EV_OFF) |-> !evt[1])
      else $error("event two with detection disabled");

   AST_IDLE_NO_EVT1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !st_reg.ctrl1[B_ON] |-> !evt[0])
      else $error("event one while comparator off");

   AST_IDLE_NO_EVT2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !st_reg.ctrl2[B_ON] |-> !evt[1])
      else $error("event two while comparator off");

   AST_RISE2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl2[B_ON] && st_reg.ctrl2[B_EVH:B_EVL] == EV_RISE && !st_reg.prev[1] && polar[1])
      |=> st_reg.pend[1])
      else $error("rising edge two missed");

   AST_FALL1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl1[B_ON] && st_reg.ctrl1[B_EVH:B_EVL] == EV_FALL && st_reg.prev[0] && !polar[0])
      |=> st_reg.pend[0])
      else $error("falling edge one missed");

   AST_FALL2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl2[B_ON] && st_reg.ctrl2[B_EVH:B_EVL] == EV_FALL && st_reg.prev[1] && !polar[1])
      |=> st_reg.pend[1])
      else $error("falling edge two missed");

   AST_BOTH1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl1[B_ON] && st_reg.ctrl1[B_EVH:B_EVL] == EV_BOTH && st_reg.prev[0] != polar[0])
      |=> st_reg.pend[0])
      else $error("any change on one missed");

   AST_BOTH2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl2[B_ON] && st_reg.ctrl2[B_EVH:B_EVL] == EV_BOTH && st_reg.prev[1] != polar[1])
      |=> st_reg.pend[1])
      else $error("any change on two missed");

   AST_RISE_ONLY1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl1[B_EVH:B_EVL] == EV_RISE && st_reg.prev[0] && !polar[0]) |-> !evt[0])
      else $error("falling edge one fired in rising mode");

   AST_RISE_ONLY2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl2[B_EVH:B_EVL] == EV_RISE && st_reg.prev[1] && !polar[1]) |-> !evt[1])
      else $error("falling edge two fired in rising mode");

   AST_FALL_ONLY1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl1[B_EVH:B_EVL] == EV_FALL && !st_reg.prev[0] && polar[0]) |-> !evt[0])
      else $error("rising edge one fired in falling mode");

   AST_FALL_ONLY2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ctrl2[B_EVH:B_EVL] == EV_FALL && !st_reg.prev[1] && polar[1]) |-> !evt[1])
      else $error("rising edge two fired in falling mode");

   //----------------------------------------------------------------
   // checks: sticky status and interrupt line
   //----------------------------------------------------------------
   AST_PEND_HOLD1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.pend[0] && !(i_wr && i_addr == OFS_ICLR && i_wdata[0])) |=> st_reg.pend[0])
      else $error("status one dropped without clear");

   AST_PEND_HOLD2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.pend[1] && !(i_wr && i_addr == OFS_ICLR && i_wdata[1])) |=> st_reg.pend[1])
      else $error("status two dropped without clear");

   AST_CLR1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_ICLR && i_wdata[0] && !evt[0]) |=> !st_reg.pend[0])
      else $error("status one not cleared");

   AST_CLR2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_ICLR && i_wdata[1] && !evt[1]) |=> !st_reg.pend[1])
      else $error("status two not cleared");

   AST_NO_SPUR1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (!st_reg.pend[0] && !evt[0]) |=> !st_reg.pend[0])
      else $error("status one set without event");

   AST_NO_SPUR2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (!st_reg.pend[1] && !evt[1]) |=> !st_reg.pend[1])
      else $error("status two set without event");

   AST_IRQ_NONE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.ien == 2'h0) |-> !o_irq)
      else $error("interrupt with nothing enabled");

   AST_RD_PEND: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_rd && i_addr == OFS_ISTAT) |=> o_rdata == {30'h00000000, $past(st_reg.pend)})
      else $error("status read mismatch");

   //----------------------------------------------------------------
   // checks: register port
   //----------------------------------------------------------------
   AST_RD_BIT8_ONE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_rd && i_addr == OFS_CTRL1) |=> o_rdata[B_RES] == $past(polar[0]))
      else $error("result bit one not sampled at read");

   AST_RD_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !i_rd |=> o_rdata == 32'h00000000)
      else $error("read data outside read slot");

   AST_CTRL_MASK: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      ((st_reg.ctrl1 | st_reg.ctrl2) & ~CTRL_WMASK) == 32'h00000000)
      else $error("read-only control bit stored");

   AST_PRIO_MASK: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (st_reg.prio & ~PRIO_WMASK) == 32'h00000000)
      else $error("unused priority bit stored");

   AST_CTRL1_WR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_CTRL1) |=> o_noninv_sel_ref[0] == $past(i_wdata[B_REF])
      && o_inv_sel[1:0] == $past(i_wdata[B_CHH:B_CHL]) && st_reg.ctrl1[B_INV] == $past(i_wdata[B_INV]))
      else $error("input selection one not stored");

   AST_CTRL2_WR: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_CTRL2) |=> o_noninv_sel_ref[1] == $past(i_wdata[B_REF])
      && o_inv_sel[3:2] == $past(i_wdata[B_CHH:B_CHL]) && st_reg.ctrl2[B_INV] == $past(i_wdata[B_INV]))
      else $error("input selection two not stored");

   AST_CTRL1_EN: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_CTRL1) |=> o_output_pin_enable[0] == $past(i_wdata[B_OE])
      && o_cmp_enable[0] == $past(i_wdata[B_ON]))
      else $error("enables one not stored");

   AST_CTRL2_EN: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (i_wr && i_addr == OFS_CTRL2) |=> o_output_pin_enable[1] == $past(i_wdata[B_OE])
      && o_cmp_enable[1] == $past(i_wdata[B_ON]))
      else $error("enables two not stored");

   AST_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !i_wr |=> $stable(st_reg.ctrl1) && $stable(st_reg.ctrl2) && $stable(st_reg.prio)
      && $stable(st_reg.ien) && $stable(st_reg.ancfg))
      else $error("register changed without write");

   //----------------------------------------------------------------
   // checks: output pins
   //----------------------------------------------------------------
   AST_PIN2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !o_output_pin_enable[1] |-> !o_comparator_out_pin[1])
      else $error("pin two driven while disabled");

   AST_PIN_RAW1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (o_output_pin_enable[0] && !st_reg.ctrl1[B_INV]) |-> o_comparator_out_pin[0] == i_cmp_raw[0])
      else $error("pin one does not follow result");

   AST_PIN_RAW2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (o_output_pin_enable[1] && !st_reg.ctrl2[B_INV]) |-> o_comparator_out_pin[1] == i_cmp_raw[1])
      else $error("pin two does not follow result");

   AST_PIN_INV1: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (o_output_pin_enable[0] && st_reg.ctrl1[B_INV]) |-> o_comparator_out_pin[0] == !i_cmp_raw[0])
      else $error("pin one not inverted");

   AST_PIN_INV2: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (o_output_pin_enable[1] && st_reg.ctrl2[B_INV]) |-> o_comparator_out_pin[1] == !i_cmp_raw[1])
      else $error("pin two not inverted");
endmodule
